// file: rtl/rst_defines.vh
// constants shared by the rail state tracker design files
`ifndef RST_DEFINES_VH
`define RST_DEFINES_VH

// ==================================================================
// state codes as reported on the state output
`define RST_STATE_W            4
`define RST_ST_IDLE            4'h1
`define RST_ST_ON_WAIT         4'h2
`define RST_ST_ON_DELAY        4'h3
`define RST_ST_RISING          4'h4
`define RST_ST_REGULATION      4'h5
`define RST_ST_OFF_WAIT        4'h6
`define RST_ST_OFF_DELAY       4'h7
`define RST_ST_FALLING         4'h8

// ==================================================================
// timing: delays are programmed in ticks of one microsecond
`define RST_DELAY_W            16
`define RST_CLOCK_PERIOD_NS    50
`define RST_TICK_NS            1000
`define RST_TICK_CYCLES        (`RST_TICK_NS / `RST_CLOCK_PERIOD_NS)
`define RST_PRESCALE_W         5
// last prescale count of one tick, tick cycles minus one
`define RST_TICK_LAST          5'h13

`endif

// file: rtl/rst_delay_counter.v
// tick-based delay counter used for turn-on and turn-off delays
`timescale 1ns/1ps
`default_nettype none
`include "rst_defines.vh"

module rst_delay_counter (
	input  wire                    i_clock,
	input  wire                    i_reset_n,
	input  wire                    i_start,
	input  wire                    i_clear,
	input  wire [`RST_DELAY_W-1:0] i_delay,
	output wire                    o_busy,
	output wire                    o_done
);

	// last prescale count of a tick, sized to the prescaler
	localparam [`RST_PRESCALE_W-1:0] TICK_LAST = `RST_TICK_LAST;

	reg                        busy_ff;
	reg                        done_ff;
	reg [`RST_DELAY_W-1:0]     remain_ff;
	reg [`RST_PRESCALE_W-1:0]  prescale_ff;
	reg                        nxt_busy;
	reg                        nxt_done;
	reg [`RST_DELAY_W-1:0]     nxt_remain;
	reg [`RST_PRESCALE_W-1:0]  nxt_prescale;

	// ==============================================================
	// next-state: prescaler makes ticks, remain counts them down
	always @* begin
		nxt_busy     = busy_ff;
		nxt_done     = 1'b0;
		nxt_remain   = remain_ff;
		nxt_prescale = prescale_ff;
		if (i_clear) begin
			nxt_busy     = 1'b0;
			nxt_prescale = {`RST_PRESCALE_W{1'b0}};
		end else if (i_start) begin
			nxt_busy     = 1'b1;
			nxt_remain   = i_delay;
			nxt_prescale = {`RST_PRESCALE_W{1'b0}};
		end else if (busy_ff) begin
			if (remain_ff == {`RST_DELAY_W{1'b0}}) begin
				nxt_busy = 1'b0; // delay has elapsed
				nxt_done = 1'b1;
			end else if (prescale_ff == TICK_LAST) begin
				nxt_prescale = {`RST_PRESCALE_W{1'b0}};
				nxt_remain   = remain_ff - 1'b1;
			end else begin
				nxt_prescale = prescale_ff + 1'b1;
			end
		end
	end

	// state flops
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_ff     <= 1'b0;
			done_ff     <= 1'b0;
			remain_ff   <= {`RST_DELAY_W{1'b0}};
			prescale_ff <= {`RST_PRESCALE_W{1'b0}};
		end else begin
			busy_ff     <= nxt_busy;
			done_ff     <= nxt_done;
			remain_ff   <= nxt_remain;
			prescale_ff <= nxt_prescale;
		end
	end

	assign o_busy = busy_ff;
	assign o_done = done_ff;

endmodule
`default_nettype wire

// file: rtl/rst_rail_tracker.v
// per-rail sequencing state machine driving one regulator enable
`timescale 1ns/1ps
`default_nettype none
`include "rst_defines.vh"

module rst_rail_tracker (
	input  wire                    i_clock,
	input  wire                    i_reset_n,
	// sequencing requests and dependency results
	input  wire                    i_turn_on_request,
	input  wire                    i_await_on_dependency,
	input  wire                    i_await_off_dependency,
	input  wire                    i_resequence_wait,
	// configuration
	input  wire [`RST_DELAY_W-1:0] i_turn_on_delay,
	input  wire [`RST_DELAY_W-1:0] i_turn_off_delay,
	input  wire                    i_pg_threshold_zero,
	input  wire                    i_turn_off_max_warning_limit,
	// monitoring and fault handling
	input  wire                    i_vout_above_pg,
	input  wire                    i_vout_discharged,
	input  wire                    i_fault_shutdown,
	input  wire                    i_fault_retry,
	// results
	output wire                    o_rail_enable,
	output wire [`RST_STATE_W-1:0] o_rail_state
);

	// ==============================================================
	// state encoding, equal to the reported codes
	localparam [`RST_STATE_W-1:0] ST_IDLE       = `RST_ST_IDLE;
	localparam [`RST_STATE_W-1:0] ST_ON_WAIT    = `RST_ST_ON_WAIT;
	localparam [`RST_STATE_W-1:0] ST_ON_DELAY   = `RST_ST_ON_DELAY;
	localparam [`RST_STATE_W-1:0] ST_RISING     = `RST_ST_RISING;
	localparam [`RST_STATE_W-1:0] ST_REGULATION = `RST_ST_REGULATION;
	localparam [`RST_STATE_W-1:0] ST_OFF_WAIT   = `RST_ST_OFF_WAIT;
	localparam [`RST_STATE_W-1:0] ST_OFF_DELAY  = `RST_ST_OFF_DELAY;
	localparam [`RST_STATE_W-1:0] ST_FALLING    = `RST_ST_FALLING;

	// ==============================================================
	// sequencing flow
	// idle -> on wait -> on delay -> rising -> regulation
	// rising or regulation -> off wait -> off delay -> falling -> idle
	// a fault in any enabled state drops the enable at once;
	// a fault under retry reports idle, not falling; a retry ends falling
	// limitation: one delay counter serves both delay states, so a
	// turn-off delay can never overlap a turn-on delay

	// ==============================================================
	// declarations
	reg  [`RST_STATE_W-1:0] state_ff;
	reg  [`RST_STATE_W-1:0] nxt_state;
	reg                     enable_ff;
	reg                     nxt_enable;
	reg                     dly_start;
	reg                     dly_clear;
	reg  [`RST_DELAY_W-1:0] dly_value;
	wire                    dly_busy;
	wire                    dly_done;
	wire                    fall_allowed;
	wire                    pg_reached;

	// ==============================================================
	// shared delay counter, used by one delay state at a time
	rst_delay_counter u_delay (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_start   (dly_start),
		.i_clear   (dly_clear),
		.i_delay   (dly_value),
		.o_busy    (dly_busy),
		.o_done    (dly_done)
	);

	// ==============================================================
	// qualifying terms

	// a zero threshold is treated as never reached
	assign pg_reached = i_vout_above_pg & ~i_pg_threshold_zero;

	// the off delay shows falling only with a finite limit, never during retry
	assign fall_allowed = ~i_turn_off_max_warning_limit & ~i_fault_retry;

	// ==============================================================
	// next-state and enable decode
	always @* begin
		nxt_state  = state_ff;
		nxt_enable = enable_ff;
		dly_start  = 1'b0;
		dly_clear  = 1'b0;
		dly_value  = i_turn_on_delay;
		case (state_ff)
			ST_IDLE: begin
				nxt_enable = 1'b0;
				// stop a delay left running by a cut sequence
				if (dly_busy) begin
					dly_clear = 1'b1;
				end
				// leave idle only with a clean request
				if (i_turn_on_request && !i_fault_shutdown &&
					!i_resequence_wait) begin
					nxt_state = ST_ON_WAIT;
				end
			end
			ST_ON_WAIT: begin
				nxt_enable = 1'b0;
				if (i_fault_shutdown || !i_turn_on_request) begin
					nxt_state = ST_IDLE;
				end else if (i_await_on_dependency) begin
					nxt_state = ST_ON_DELAY;
					dly_start = 1'b1;
					dly_value = i_turn_on_delay;
				end
			end
			ST_ON_DELAY: begin
				nxt_enable = 1'b0;
				if (i_fault_shutdown || !i_turn_on_request) begin
					nxt_state = ST_IDLE;
					dly_clear = 1'b1;
				end else if (dly_done) begin
					nxt_state  = ST_RISING;
					nxt_enable = 1'b1;
				end
			end
			ST_RISING: begin
				nxt_enable = 1'b1;
				if (i_fault_shutdown) begin
					nxt_enable = 1'b0;
					// fault turn-off shows falling whatever the limit, idle under retry
					if (i_fault_retry) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_FALLING;
					end
				end else if (!i_turn_on_request) begin
					nxt_state = ST_OFF_WAIT;
				end else if (pg_reached && enable_ff) begin
					nxt_state = ST_REGULATION;
				end
			end
			ST_REGULATION: begin
				nxt_enable = 1'b1;
				// voltage sag alone does not leave regulation
				if (i_fault_shutdown) begin
					nxt_enable = 1'b0;
					if (i_fault_retry) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_FALLING;
					end
				end else if (!i_turn_on_request) begin
					nxt_state = ST_OFF_WAIT;
				end
			end
			ST_OFF_WAIT: begin
				nxt_enable = 1'b1;
				if (i_fault_shutdown) begin
					nxt_enable = 1'b0;
					if (i_fault_retry) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_FALLING;
					end
				end else if (i_await_off_dependency) begin
					nxt_state = ST_OFF_DELAY;
					dly_start = 1'b1;
					dly_value = i_turn_off_delay;
				end
			end
			ST_OFF_DELAY: begin
				nxt_enable = 1'b1;
				dly_value  = i_turn_off_delay;
				if (i_fault_shutdown) begin
					nxt_enable = 1'b0;
					dly_clear  = 1'b1;
					if (i_fault_retry) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_state = ST_FALLING;
					end
				end else if (dly_done) begin
					nxt_enable = 1'b0;
					if (fall_allowed) begin
						nxt_state = ST_FALLING;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_FALLING: begin
				nxt_enable = 1'b0;
				// a retry that starts while falling shows idle
				if (i_vout_discharged || i_fault_retry) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state  = ST_IDLE;
				nxt_enable = 1'b0;
				dly_clear  = 1'b1;
			end
		endcase
	end

	// ==============================================================
	// state and enable flops; reset lands in idle, enable off
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff  <= ST_IDLE;
			enable_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			enable_ff <= nxt_enable;
		end
	end

	// ==============================================================
	// outputs straight from flops
	assign o_rail_enable = enable_ff;
	assign o_rail_state  = state_ff;

endmodule
`default_nettype wire

// file: test/rst_rail_checker.sv
// concurrent checks on the rail state tracker ports
`timescale 1ns/1ps
`default_nettype none
`include "rst_defines.vh"
module rst_rail_checker (
	input wire logic                    i_clock,
	input wire logic                    i_reset_n,
	input wire logic                    i_turn_on_request,
	input wire logic                    i_await_on_dependency,
	input wire logic                    i_await_off_dependency,
	input wire logic                    i_resequence_wait,
	input wire logic                    i_pg_threshold_zero,
	input wire logic                    i_vout_above_pg,
	input wire logic                    i_vout_discharged,
	input wire logic                    i_fault_shutdown,
	input wire logic                    i_fault_retry,
	input wire logic                    o_rail_enable,
	input wire logic [`RST_STATE_W-1:0] o_rail_state
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	wire logic ok_on  = i_turn_on_request && !i_fault_shutdown;
	wire logic run    = o_rail_state inside {[4:7]};
	// ===============================================================
	// state codes and enable
	a_state_range: assert property (o_rail_state inside {[1:8]})
		else $error("state code out of range");
	a_enable_map: assert property (o_rail_enable == run)
		else $error("enable disagrees with state");
	// ===============================================================
	// transitions
	a_idle_leave: assert property (o_rail_state == 1 && ok_on
		&& !i_resequence_wait |=> o_rail_state == 2)
		else $error("idle did not start sequencing");
	a_on_wait: assert property (o_rail_state == 2 && ok_on
		&& !i_await_on_dependency |=> o_rail_state == 2)
		else $error("on wait left early");
	a_zero_pg: assert property (o_rail_state == 4 && ok_on
		&& i_pg_threshold_zero |=> o_rail_state == 4)
		else $error("zero threshold left rising");
	a_rise_reg: assert property (o_rail_state == 4 && ok_on
		&& !i_pg_threshold_zero && i_vout_above_pg |=> o_rail_state == 5)
		else $error("rising missed regulation");
	a_reg_hold: assert property (o_rail_state == 5 && ok_on
		|=> o_rail_state == 5)
		else $error("regulation not held");
	a_off_wait: assert property (o_rail_state == 6 && !ok_on
		&& !i_fault_shutdown && !i_await_off_dependency
		|=> o_rail_state == 6)
		else $error("off wait left early");
	a_fault_fall: assert property (run && i_fault_shutdown
		&& !i_fault_retry |=> o_rail_state == 8 && !o_rail_enable)
		else $error("fault did not fall");
	a_retry_idle: assert property (run && i_fault_shutdown
		&& i_fault_retry |=> o_rail_state == 1)
		else $error("retry did not show idle");
	a_fall_end: assert property (o_rail_state == 8
		&& (i_vout_discharged || i_fault_retry) |=> o_rail_state == 1)
		else $error("falling did not end");
	c_reg: cover property (o_rail_state == 5);
	c_off_delay: cover property (o_rail_state == 7);
	c_fall: cover property (o_rail_state == 8);
	c_retry_fall: cover property (o_rail_state == 8 && i_fault_retry);
endmodule
bind rst_rail_tracker rst_rail_checker i_chk (.i_clock, .i_reset_n,
	.i_turn_on_request, .i_await_on_dependency, .i_await_off_dependency,
	.i_resequence_wait, .i_pg_threshold_zero, .i_vout_above_pg,
	.i_vout_discharged, .i_fault_shutdown, .i_fault_retry,
	.o_rail_enable, .o_rail_state);
`default_nettype wire

// file: test/rst_rail_tracker_tb.sv
// self-checking bench driving the tracker against a regulator model
`timescale 1ns/1ps
`default_nettype none
`include "rst_defines.vh"
module rst_rail_tracker_tb;
	localparam int TON = 2 * `RST_TICK_CYCLES + 2;
	localparam int TOFF = 1 * `RST_TICK_CYCLES + 2;
	logic        i_clock, i_reset_n, req, on_dep, off_dep, reseq, pg_zero;
	logic        unlim, above, dis, fault, retry, sag, en;
	logic [15:0] on_d, off_d;
	logic [3:0]  st;
	int          mismatches, n_checks;
	rst_rail_tracker i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_turn_on_request(req), .i_await_on_dependency(on_dep),
		.i_await_off_dependency(off_dep), .i_resequence_wait(reseq),
		.i_turn_on_delay(on_d), .i_turn_off_delay(off_d),
		.i_pg_threshold_zero(pg_zero),
		.i_turn_off_max_warning_limit(unlim), .i_vout_above_pg(above),
		.i_vout_discharged(dis), .i_fault_shutdown(fault),
		.i_fault_retry(retry), .o_rail_enable(en), .o_rail_state(st));
	rst_regulator_model #(.RAMP(10)) i_reg (.i_clock(i_clock),
		.i_reset_n(i_reset_n), .i_enable(en), .i_sag(sag),
		.o_vout_above_pg(above), .o_vout_discharged(dis));
	// ===============================================================
	// clock and helpers
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic expect_st(input logic [3:0] code, input logic e);
		check({4'h0, st}, {4'h0, code});
		check({7'h00, en}, {7'h00, e});
	endtask
	// wait for a code; a non-negative exp checks edges taken
	task automatic go(input logic [3:0] code, input int exp);
		int n;
		n = 0;
		while (st !== code && n < 400) begin
			@(negedge i_clock);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
			wrap_up();
		end else if (exp >= 0) begin
			check(8'(n), 8'(exp));
		end
	endtask
	// ===============================================================
	// scenarios
	initial begin
		{req, on_dep, off_dep, reseq, pg_zero, unlim, fault, retry} <= '0;
		sag <= 1'b0;
		on_d <= 16'h0002;
		off_d <= 16'h0001;
		mismatches = 0;
		n_checks = 0;
		i_reset_n = 1'b0;
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		req <= 1'b1;
		reseq <= 1'b1;
		repeat (3) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		reseq <= 1'b0;
		fault <= 1'b1;
		repeat (3) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		fault <= 1'b0;
		go(4'h2, -1);
		repeat (4) @(negedge i_clock);
		expect_st(4'h2, 1'b0);
		@(posedge i_clock);
		on_dep <= 1'b1;
		go(4'h3, -1);
		go(4'h4, TON);
		expect_st(4'h4, 1'b1);
		go(4'h5, -1);
		@(posedge i_clock);
		sag <= 1'b1;
		repeat (4) @(negedge i_clock);
		expect_st(4'h5, 1'b1);
		@(posedge i_clock);
		sag <= 1'b0;
		req <= 1'b0;
		go(4'h6, -1);
		repeat (4) @(negedge i_clock);
		expect_st(4'h6, 1'b1);
		@(posedge i_clock);
		off_dep <= 1'b1;
		go(4'h7, -1);
		go(4'h8, TOFF);
		expect_st(4'h8, 1'b0);
		go(4'h1, -1);
		@(posedge i_clock);
		unlim <= 1'b1;
		on_d <= 16'h0000;
		req <= 1'b1;
		go(4'h3, -1);
		go(4'h4, 2);
		go(4'h5, -1);
		@(posedge i_clock);
		req <= 1'b0;
		go(4'h7, -1);
		go(4'h1, TOFF);
		@(posedge i_clock);
		pg_zero <= 1'b1;
		req <= 1'b1;
		go(4'h4, -1);
		repeat (20) @(negedge i_clock);
		expect_st(4'h4, 1'b1);
		@(posedge i_clock);
		fault <= 1'b1;
		retry <= 1'b1;
		repeat (2) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		fault <= 1'b0;
		retry <= 1'b0;
		go(4'h4, -1);
		@(posedge i_clock);
		fault <= 1'b1;
		repeat (2) @(negedge i_clock);
		expect_st(4'h8, 1'b0);
		@(posedge i_clock);
		fault <= 1'b0;
		req <= 1'b0;
		go(4'h1, -1);
		// a fault and a request drop each cut the turn-on delay
		@(posedge i_clock);
		on_d <= 16'h0002;
		req <= 1'b1;
		go(4'h3, -1);
		@(posedge i_clock);
		fault <= 1'b1;
		repeat (2) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		fault <= 1'b0;
		go(4'h3, -1);
		@(posedge i_clock);
		req <= 1'b0;
		repeat (2) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		req <= 1'b1;
		go(4'h3, -1);
		go(4'h4, TON);
		// fault in the off delay, then a retry ends falling
		@(posedge i_clock);
		req <= 1'b0;
		go(4'h7, -1);
		@(posedge i_clock);
		fault <= 1'b1;
		repeat (2) @(negedge i_clock);
		expect_st(4'h8, 1'b0);
		@(posedge i_clock);
		fault <= 1'b0;
		retry <= 1'b1;
		repeat (2) @(negedge i_clock);
		expect_st(4'h1, 1'b0);
		@(posedge i_clock);
		retry <= 1'b0;
		wrap_up();
	end
endmodule
`default_nettype wire

// file: test/rst_regulator_model.sv
// behavioural regulator answering the rail enable with a voltage ramp
`timescale 1ns/1ps
`default_nettype none
module rst_regulator_model #(parameter int RAMP = 10) (
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	input  wire logic i_enable,
	input  wire logic i_sag,
	output wire logic o_vout_above_pg,
	output wire logic o_vout_discharged
);
	int level_ff;
	// output climbs while enabled and decays while disabled
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n)
			level_ff <= 0;
		else if (i_enable && level_ff < RAMP)
			level_ff <= level_ff + 1;
		else if (!i_enable && level_ff > 0)
			level_ff <= level_ff - 1;
	end
	// sag drops the power-good reading on command
	assign o_vout_above_pg   = (level_ff == RAMP) && !i_sag;
	assign o_vout_discharged = (level_ff == 0);
endmodule
`default_nettype wire
